// file: hw/nsmr_map.svh
// register offsets, field positions, reset values and limits of the status/mode block
`ifndef NSMR_MAP_SVH
`define NSMR_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define NSMR_OFS_STATUS 8'h00
`define NSMR_OFS_OPMODE 8'h04
`define NSMR_OFS_IRQ_STAT 8'h08
`define NSMR_OFS_IRQ_MASK 8'h0C

// ==========================================================
// status register field positions
`define NSMR_TX_DONE 0
`define NSMR_TX_HALTED 1
`define NSMR_TX_BUF_UNAVAIL 2
`define NSMR_TX_JABBER 3
`define NSMR_TX_UNDERFLOW 5
`define NSMR_RX_DONE 6
`define NSMR_RX_BUF_UNAVAIL 7
`define NSMR_RX_HALTED 8
`define NSMR_RX_WATCHDOG 9
`define NSMR_SYS_BUS_ERR 13
`define NSMR_ABNORMAL_SUM 15
`define NSMR_NORMAL_SUM 16
`define NSMR_FLAG_MASK 14'h23EF
`define NSMR_NORMAL_MASK 14'h0045
`define NSMR_ABNORMAL_MASK 14'h23AA

// ==========================================================
// operation mode field positions and reset values
`define NSMR_ACCEPT_ALL 30
`define NSMR_KEEP_FIFO 29
`define NSMR_FIXED_ONE 25
`define NSMR_THRESH_SPEED 22
`define NSMR_THRESH_SEL_HI 15
`define NSMR_THRESH_SEL_LO 14
`define NSMR_RST_ACCEPT_ALL 1'b0
`define NSMR_RST_KEEP_FIFO 1'b0
`define NSMR_RST_THRESH_SPEED 1'b1
`define NSMR_RST_THRESH_SEL 2'h0
`define NSMR_RST_MASK 14'h0000

// ==========================================================
// limits and thresholds in bytes
`define NSMR_JABBER_BYTES 16'h0800
`define NSMR_TH100_0 11'h080
`define NSMR_TH100_1 11'h100
`define NSMR_TH100_2 11'h200
`define NSMR_TH100_3 11'h400
`define NSMR_TH10_0 11'h040
`define NSMR_TH10_1 11'h080
`define NSMR_TH10_2 11'h0C0
`define NSMR_TH10_3 11'h100

// ==========================================================
// bus answers
`define NSMR_RESP_OKAY 2'h0
`define NSMR_RESP_SLVERR 2'h2

`endif

// file: hw/nsmr_pkg.sv
// types shared by the status/mode block
package nsmr_pkg;

   typedef logic [13:0] nsmr_flags_t;

   typedef enum logic {
      NSMR_WR_IDLE = 1'b0,
      NSMR_WR_RESP = 1'b1
   } nsmr_wr_t;

   typedef enum logic [2:0] {
      NSMR_REG_STATUS = 3'h0,
      NSMR_REG_OPMODE = 3'h1,
      NSMR_REG_IRQ_STAT = 3'h2,
      NSMR_REG_IRQ_MASK = 3'h3,
      NSMR_REG_NONE = 3'h4
   } nsmr_reg_t;

   typedef struct packed {
      nsmr_flags_t flags;
   } nsmr_bank_t;

   typedef struct packed {
      nsmr_wr_t wr_st;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic accept_all;
      logic keep_fifo;
      logic thresh_speed;
      logic [1:0] thresh_sel;
      nsmr_flags_t mask;
      logic irq;
      logic jab_seen;
      logic rx_suspend;
      logic tx_suspend;
      logic tx_abort;
      logic tx_desc0_underrun;
      logic tx_desc0_jabber;
      logic rx_accept;
      logic rx_desc0_match;
      logic rx_purge;
      logic tx_start;
      logic [10:0] start_level;
   } nsmr_regs_t;

endpackage

// file: hw/nsmr_flag_bank.sv
// sticky flag bank: hardware sets, clear vector clears, set wins
`timescale 1ns/1ns
`include "nsmr_map.svh"

module nsmr_flag_bank (
   input wire logic core_clk,
   input wire logic rst,
   input wire nsmr_pkg::nsmr_flags_t set_vec,
   input wire nsmr_pkg::nsmr_flags_t clr_vec,
   output nsmr_pkg::nsmr_flags_t flags
);
   import nsmr_pkg::*;

   nsmr_bank_t bank_ff;
   nsmr_bank_t nxt_bank;

   // ==========================================================
   // next state
   always_comb begin
      nxt_bank = bank_ff;
      for (int i = 0; i < 14; i++) begin
         if (set_vec[i]) begin
            nxt_bank.flags[i] = 1'b1;
         end else if (clr_vec[i]) begin
            nxt_bank.flags[i] = 1'b0;
         end
      end
      nxt_bank.flags = nxt_bank.flags & `NSMR_FLAG_MASK;
   end

   // ==========================================================
   // registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bank_ff <= '0;
      end else begin
         bank_ff <= nxt_bank;
      end
   end

   assign flags = bank_ff.flags;

endmodule

// file: hw/nsmr_top.sv
// network status flags and operation mode registers behind an AXI4-Lite slave
// Contract
// - rx descriptor host-owned sets flag, suspends rx
// - rx frame stored and closed sets rx done
// - tx underrun sets flag, suspends, marks descriptor
// - over 2048 bytes: jabber flag, abort, mark
// - tx descriptor host-owned sets flag, suspends tx
// - tx entering stopped state sets halted flag
// - tx frame closed with done bit sets flag
// - accept-all takes every frame, reports match
// - keep-fifo bit stops purge on no buffer
// - speed bit resets one, selects 10/100 mode
// - status bits 13..0 clear on written one
// - normal summary ORs tx done, tx unavail, rx done
// - abnormal summary ORs the seven error flags
// - transmit starts once fifo exceeds threshold
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "nsmr_map.svh"

module nsmr_top (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_desc_host_owned,
   input wire logic rx_frame_closed,
   input wire logic rx_new_frame,
   input wire logic rx_poll_demand,
   input wire logic rx_enter_stopped,
   input wire logic rx_watchdog_expired,
   input wire logic rx_addr_match,
   input wire logic sys_bus_fault,
   input wire logic tx_desc_host_owned,
   input wire logic tx_frame_closed,
   input wire logic tx_desc1_done,
   input wire logic tx_underrun_seen,
   input wire logic tx_active,
   input wire logic [15:0] tx_byte_cnt,
   input wire logic tx_enter_stopped,
   input wire logic tx_poll_demand,
   input wire logic tx_auto_poll_expired,
   input wire logic [11:0] tx_fifo_level,
   output logic rx_suspend,
   output logic rx_purge,
   output logic rx_accept,
   output logic rx_desc0_match,
   output logic keep_rx_fifo,
   output logic accept_all_rx,
   output logic tx_suspend,
   output logic tx_abort,
   output logic tx_desc0_underrun,
   output logic tx_desc0_jabber,
   output logic tx_start,
   output logic [10:0] tx_start_level,
   output logic irq
);
   import nsmr_pkg::*;

   nsmr_regs_t regs_ff;
   nsmr_regs_t nxt_regs;
   nsmr_flags_t stat_flags;
   nsmr_flags_t irq_flags;
   nsmr_flags_t events;
   nsmr_flags_t stat_clr;
   nsmr_flags_t irq_clr;
   logic jab_ev;

   // ==========================================================
   // address decode, shared by read and write paths
   function automatic nsmr_reg_t nsmr_decode(input logic [7:0] addr);
      nsmr_reg_t sel;
      sel = NSMR_REG_NONE;
      unique case ({addr[7:2], 2'b00})
         `NSMR_OFS_STATUS: sel = NSMR_REG_STATUS;
         `NSMR_OFS_OPMODE: sel = NSMR_REG_OPMODE;
         `NSMR_OFS_IRQ_STAT: sel = NSMR_REG_IRQ_STAT;
         `NSMR_OFS_IRQ_MASK: sel = NSMR_REG_IRQ_MASK;
         default: sel = NSMR_REG_NONE;
      endcase
      return sel;
   endfunction

   // ==========================================================
   // transmit start level from speed mode and select bits
   function automatic logic [10:0] nsmr_thresh(input logic speed, input logic [1:0] sel);
      logic [10:0] lvl;
      lvl = `NSMR_TH100_0;
      unique case ({speed, sel})
         3'h0: lvl = `NSMR_TH100_0;
         3'h1: lvl = `NSMR_TH100_1;
         3'h2: lvl = `NSMR_TH100_2;
         3'h3: lvl = `NSMR_TH100_3;
         3'h4: lvl = `NSMR_TH10_0;
         3'h5: lvl = `NSMR_TH10_1;
         3'h6: lvl = `NSMR_TH10_2;
         3'h7: lvl = `NSMR_TH10_3;
      endcase
      return lvl;
   endfunction

   // ==========================================================
   // byte-strobe expansion for the low flag half
   function automatic nsmr_flags_t nsmr_lane_mask(input logic [3:0] strb);
      nsmr_flags_t m;
      m = {{6{strb[1]}}, {8{strb[0]}}};
      return m;
   endfunction

   // ==========================================================
   // event detection
   always_comb begin
      events = '0;
      jab_ev = tx_active && (tx_byte_cnt > `NSMR_JABBER_BYTES) && !regs_ff.jab_seen;
      events[`NSMR_TX_DONE] = tx_frame_closed && tx_desc1_done;
      events[`NSMR_TX_HALTED] = tx_enter_stopped || jab_ev;
      events[`NSMR_TX_BUF_UNAVAIL] = tx_desc_host_owned;
      events[`NSMR_TX_JABBER] = jab_ev;
      events[`NSMR_TX_UNDERFLOW] = tx_underrun_seen;
      events[`NSMR_RX_DONE] = rx_frame_closed;
      events[`NSMR_RX_BUF_UNAVAIL] = rx_desc_host_owned;
      events[`NSMR_RX_HALTED] = rx_enter_stopped;
      events[`NSMR_RX_WATCHDOG] = rx_watchdog_expired;
      events[`NSMR_SYS_BUS_ERR] = sys_bus_fault;
   end

   // ==========================================================
   // sticky flags: software-visible status and interrupt status
   nsmr_flag_bank u_stat_bank (
      .core_clk(core_clk),
      .rst(rst),
      .set_vec(events),
      .clr_vec(stat_clr),
      .flags(stat_flags)
   );

   nsmr_flag_bank u_irq_bank (
      .core_clk(core_clk),
      .rst(rst),
      .set_vec(events),
      .clr_vec(irq_clr),
      .flags(irq_flags)
   );

   // ==========================================================
   // next state
   always_comb begin
      nsmr_reg_t wsel;
      nsmr_reg_t rsel;
      logic do_write;
      logic do_read;
      nsmr_flags_t wmask;
      wsel = nsmr_decode(regs_ff.aw_addr);
      wmask = nsmr_lane_mask(regs_ff.w_strb);
      rsel = nsmr_decode(s_axi_araddr);
      nxt_regs = regs_ff;
      stat_clr = '0;
      irq_clr = '0;
      do_write = 1'b0;
      do_read = s_axi_arvalid && regs_ff.arready;

      // write channel: address and data taken in either order
      if (s_axi_awvalid && regs_ff.awready) begin
         nxt_regs.aw_got = 1'b1;
         nxt_regs.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && regs_ff.wready) begin
         nxt_regs.w_got = 1'b1;
         nxt_regs.w_data = s_axi_wdata;
         nxt_regs.w_strb = s_axi_wstrb;
      end
      unique case (regs_ff.wr_st)
         NSMR_WR_IDLE: begin
            if (regs_ff.aw_got && regs_ff.w_got) begin
               do_write = 1'b1;
               nxt_regs.aw_got = 1'b0;
               nxt_regs.w_got = 1'b0;
               nxt_regs.bvalid = 1'b1;
               nxt_regs.bresp = (wsel == NSMR_REG_NONE) ? `NSMR_RESP_SLVERR : `NSMR_RESP_OKAY;
               nxt_regs.wr_st = NSMR_WR_RESP;
            end
         end
         NSMR_WR_RESP: begin
            if (s_axi_bready) begin
               nxt_regs.bvalid = 1'b0;
               nxt_regs.wr_st = NSMR_WR_IDLE;
            end
         end
      endcase
      nxt_regs.awready = !nxt_regs.aw_got && (nxt_regs.wr_st == NSMR_WR_IDLE);
      nxt_regs.wready = !nxt_regs.w_got && (nxt_regs.wr_st == NSMR_WR_IDLE);

      // register writes; bits outside the fields are dropped
      if (do_write) begin
         unique case (wsel)
            NSMR_REG_STATUS: begin
               stat_clr = regs_ff.w_data[13:0] & wmask;
            end
            NSMR_REG_OPMODE: begin
               if (regs_ff.w_strb[3]) begin
                  nxt_regs.accept_all = regs_ff.w_data[`NSMR_ACCEPT_ALL];
                  nxt_regs.keep_fifo = regs_ff.w_data[`NSMR_KEEP_FIFO];
               end
               if (regs_ff.w_strb[2]) begin
                  nxt_regs.thresh_speed = regs_ff.w_data[`NSMR_THRESH_SPEED];
               end
               if (regs_ff.w_strb[1]) begin
                  nxt_regs.thresh_sel = regs_ff.w_data[`NSMR_THRESH_SEL_HI:`NSMR_THRESH_SEL_LO];
               end
            end
            NSMR_REG_IRQ_MASK: begin
               for (int i = 0; i < 14; i++) begin
                  if (wmask[i]) begin
                     nxt_regs.mask[i] = regs_ff.w_data[i];
                  end
               end
               nxt_regs.mask = nxt_regs.mask & `NSMR_FLAG_MASK;
            end
            NSMR_REG_IRQ_STAT: ;
            NSMR_REG_NONE: ;
            default: ;
         endcase
      end

      // read channel
      if (regs_ff.rvalid && s_axi_rready) begin
         nxt_regs.rvalid = 1'b0;
      end
      if (do_read) begin
         nxt_regs.rvalid = 1'b1;
         nxt_regs.rresp = `NSMR_RESP_OKAY;
         nxt_regs.rdata = '0;
         unique case (rsel)
            NSMR_REG_STATUS: begin
               nxt_regs.rdata[13:0] = stat_flags;
               nxt_regs.rdata[`NSMR_NORMAL_SUM] = |(stat_flags & `NSMR_NORMAL_MASK);
               nxt_regs.rdata[`NSMR_ABNORMAL_SUM] = |(stat_flags & `NSMR_ABNORMAL_MASK);
            end
            NSMR_REG_OPMODE: begin
               nxt_regs.rdata[`NSMR_ACCEPT_ALL] = regs_ff.accept_all;
               nxt_regs.rdata[`NSMR_KEEP_FIFO] = regs_ff.keep_fifo;
               nxt_regs.rdata[`NSMR_FIXED_ONE] = 1'b1;
               nxt_regs.rdata[`NSMR_THRESH_SPEED] = regs_ff.thresh_speed;
               nxt_regs.rdata[`NSMR_THRESH_SEL_HI:`NSMR_THRESH_SEL_LO] = regs_ff.thresh_sel;
            end
            NSMR_REG_IRQ_STAT: begin
               nxt_regs.rdata[13:0] = irq_flags;
               irq_clr = irq_flags;
            end
            NSMR_REG_IRQ_MASK: begin
               nxt_regs.rdata[13:0] = regs_ff.mask;
            end
            NSMR_REG_NONE: begin
               nxt_regs.rresp = `NSMR_RESP_SLVERR;
            end
            default: ;
         endcase
      end
      nxt_regs.arready = !nxt_regs.rvalid;

      // interrupt: unmasked interrupt-status bits
      nxt_regs.irq = |(irq_flags & ~irq_clr & nxt_regs.mask);

      // jabber fires once per transmission
      if (!tx_active) begin
         nxt_regs.jab_seen = 1'b0;
      end else if (jab_ev) begin
         nxt_regs.jab_seen = 1'b1;
      end
      nxt_regs.tx_abort = jab_ev;
      nxt_regs.tx_desc0_jabber = jab_ev;
      nxt_regs.tx_desc0_underrun = tx_underrun_seen;

      // transmit suspend: buffer unavailable or underrun until a poll or a jabber abort
      if (tx_desc_host_owned || tx_underrun_seen) begin
         nxt_regs.tx_suspend = 1'b1;
      end else if (tx_poll_demand || tx_auto_poll_expired || jab_ev) begin
         nxt_regs.tx_suspend = 1'b0;
      end

      // receive suspend: until a new frame or a poll
      if (rx_desc_host_owned) begin
         nxt_regs.rx_suspend = 1'b1;
      end else if (rx_new_frame || rx_poll_demand) begin
         nxt_regs.rx_suspend = 1'b0;
      end
      nxt_regs.rx_purge = nxt_regs.rx_suspend && !nxt_regs.keep_fifo;

      // address filter still evaluated; accept-all overrides the drop
      nxt_regs.rx_accept = nxt_regs.accept_all || rx_addr_match;
      nxt_regs.rx_desc0_match = rx_addr_match;

      // transmit start level and start decision
      nxt_regs.start_level = nsmr_thresh(nxt_regs.thresh_speed, nxt_regs.thresh_sel);
      nxt_regs.tx_start = tx_fifo_level > {1'b0, regs_ff.start_level};
   end

   // ==========================================================
   // registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         regs_ff <= '0;
         regs_ff.wr_st <= NSMR_WR_IDLE;
         regs_ff.awready <= 1'b1;
         regs_ff.wready <= 1'b1;
         regs_ff.arready <= 1'b1;
         regs_ff.accept_all <= `NSMR_RST_ACCEPT_ALL;
         regs_ff.keep_fifo <= `NSMR_RST_KEEP_FIFO;
         regs_ff.thresh_speed <= `NSMR_RST_THRESH_SPEED;
         regs_ff.thresh_sel <= `NSMR_RST_THRESH_SEL;
         regs_ff.mask <= `NSMR_RST_MASK;
         regs_ff.start_level <= `NSMR_TH10_0;
      end else begin
         regs_ff <= nxt_regs;
      end
   end

   // ==========================================================
   // outputs, all straight from flip-flops
   assign s_axi_awready = regs_ff.awready;
   assign s_axi_wready = regs_ff.wready;
   assign s_axi_bvalid = regs_ff.bvalid;
   assign s_axi_bresp = regs_ff.bresp;
   assign s_axi_arready = regs_ff.arready;
   assign s_axi_rvalid = regs_ff.rvalid;
   assign s_axi_rdata = regs_ff.rdata;
   assign s_axi_rresp = regs_ff.rresp;
   assign rx_suspend = regs_ff.rx_suspend;
   assign rx_purge = regs_ff.rx_purge;
   assign rx_accept = regs_ff.rx_accept;
   assign rx_desc0_match = regs_ff.rx_desc0_match;
   assign keep_rx_fifo = regs_ff.keep_fifo;
   assign accept_all_rx = regs_ff.accept_all;
   assign tx_suspend = regs_ff.tx_suspend;
   assign tx_abort = regs_ff.tx_abort;
   assign tx_desc0_underrun = regs_ff.tx_desc0_underrun;
   assign tx_desc0_jabber = regs_ff.tx_desc0_jabber;
   assign tx_start = regs_ff.tx_start;
   assign tx_start_level = regs_ff.start_level;
   assign irq = regs_ff.irq;

endmodule

// file: test/nsmr_checker_assertions.sv
// concurrent checks on the status/mode block ports
`timescale 1ns/1ns

module nsmr_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic rx_desc_host_owned,
   input wire logic rx_suspend,
   input wire logic keep_rx_fifo,
   input wire logic rx_purge,
   input wire logic accept_all_rx,
   input wire logic rx_accept,
   input wire logic tx_underrun_seen,
   input wire logic tx_suspend,
   input wire logic tx_desc0_underrun,
   input wire logic tx_abort,
   input wire logic tx_desc0_jabber,
   input wire logic tx_active,
   input wire logic [15:0] tx_byte_cnt,
   input wire logic [11:0] tx_fifo_level,
   input wire logic tx_start,
   input wire logic [10:0] tx_start_level
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // ==========================================================
   // bus handshakes
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      s_axi_bvalid && !s_axi_awready && !s_axi_wready;
   endsequence
   sequence s_jab_cause;
      $past(tx_active) && ($past(tx_byte_cnt) > 16'h0800) && tx_desc0_jabber;
   endsequence

   a_write_answer: assert property (s_wr_both |=> !s_axi_awready ##1 s_wr_answer)
      else $error("write answer not two cycles after address and data");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after address");

   // ==========================================================
   // engine side effects
   a_rx_suspend: assert property (rx_desc_host_owned |=> rx_suspend)
      else $error("rx not suspended after host-owned descriptor");
   a_underrun_mark: assert property (tx_underrun_seen |=> tx_suspend && tx_desc0_underrun)
      else $error("underrun did not suspend and mark descriptor");
   a_jabber_pulse: assert property (tx_abort |-> s_jab_cause ##1 !tx_abort)
      else $error("abort pulse without jabber cause or too long");
   a_keep_no_purge: assert property (keep_rx_fifo && $past(keep_rx_fifo) |-> !rx_purge)
      else $error("fifo purged while keep bit set");
   a_accept_all: assert property (accept_all_rx && $past(accept_all_rx) |-> rx_accept)
      else $error("frame refused while accept-all set");
   a_start_level: assert property (tx_start ==
      ($past(tx_fifo_level) > {1'b0, $past(tx_start_level)}))
      else $error("transmit start not tied to fifo level above threshold");
   a_level_table: assert property (tx_start_level inside
      {11'h040, 11'h080, 11'h0C0, 11'h100, 11'h200, 11'h400})
      else $error("start level outside threshold table");
endmodule

bind nsmr_top nsmr_checker chk_u (.*);

// file: test/nsmr_engine_model.sv
// descriptor engine stand-in: one-cycle event pulses on command
`timescale 1ns/1ns

module nsmr_engine_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ev_go,
   input wire logic [3:0] ev_code,
   output logic rx_desc_host_owned,
   output logic rx_frame_closed,
   output logic rx_new_frame,
   output logic rx_poll_demand,
   output logic rx_enter_stopped,
   output logic rx_watchdog_expired,
   output logic sys_bus_fault,
   output logic tx_desc_host_owned,
   output logic tx_frame_closed,
   output logic tx_desc1_done,
   output logic tx_underrun_seen,
   output logic tx_active,
   output logic [15:0] tx_byte_cnt,
   output logic tx_enter_stopped,
   output logic tx_poll_demand,
   output logic tx_auto_poll_expired
);
   logic [15:0] p;
   logic done;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         p <= 16'h0000;
         done <= 1'b0;
      end else begin
         p <= 16'h0000;
         p[ev_code] <= ev_go;
         done <= ev_go && (ev_code == 4'h8);
      end
   end

   assign rx_desc_host_owned = p[0];
   assign rx_frame_closed = p[1];
   assign rx_new_frame = p[2];
   assign rx_poll_demand = p[3];
   assign rx_enter_stopped = p[4];
   assign rx_watchdog_expired = p[5];
   assign sys_bus_fault = p[6];
   assign tx_desc_host_owned = p[7];
   assign tx_frame_closed = p[8] | p[14];
   assign tx_desc1_done = done;
   assign tx_underrun_seen = p[9];
   assign tx_enter_stopped = p[10];
   assign tx_poll_demand = p[11];
   assign tx_auto_poll_expired = p[12];
   // one burst just past the jabber limit
   assign tx_active = p[13];
   assign tx_byte_cnt = p[13] ? 16'h0801 : 16'h0000;
endmodule

// file: test/tb.sv
// self-checking bench for the status/mode register block
`timescale 1ns/1ns
`include "nsmr_map.svh"

module tb;
   logic core_clk, rst = 1'b1, ev_go = 1'b0, rx_addr_match = 1'b0;
   logic [3:0] ev_code = 4'h0, s_axi_wstrb = 4'hF;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic rx_desc_host_owned, rx_frame_closed, rx_new_frame, rx_poll_demand, rx_enter_stopped;
   logic rx_watchdog_expired, sys_bus_fault, tx_desc_host_owned, tx_frame_closed, tx_desc1_done;
   logic tx_underrun_seen, tx_active, tx_enter_stopped, tx_poll_demand, tx_auto_poll_expired;
   logic rx_suspend, rx_purge, rx_accept, rx_desc0_match, keep_rx_fifo, accept_all_rx;
   logic tx_suspend, tx_abort, tx_desc0_underrun, tx_desc0_jabber, tx_start, irq;
   logic [15:0] tx_byte_cnt;
   logic [11:0] tx_fifo_level = 12'h000;
   logic [10:0] tx_start_level;
   logic [3:0] ecode [11] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hD, 4'hE};
   logic [31:0] estat [11] = '{32'h8080, 32'h10040, 32'h8100, 32'h8200, 32'hA000, 32'h10004,
                              32'h10001, 32'h8020, 32'h8002, 32'h800A, 32'h0};
   logic [31:0] thr [8] = '{32'h80, 32'h100, 32'h200, 32'h400, 32'h40, 32'h80, 32'hC0, 32'h100};
   int err_count = 0;
   int n_tests = 0;

   nsmr_top dut_u (.*);
   nsmr_engine_model eng_u (.*);

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ==========================================================
   // bench tasks
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic tmo;
      err_count++;
      $display("timeout at %0t", $time);
      end_sim();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
         if (n > 40) tmo();
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
         if (n > 40) tmo();
      end while (!s_axi_rvalid);
      rsp = s_axi_rresp;
      rdat = s_axi_rdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rdat, e);
   endtask

   task automatic ev(input logic [3:0] c);
      ev_code <= c;
      ev_go <= 1'b1;
      @(posedge core_clk);
      ev_go <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rdc(`NSMR_OFS_OPMODE, 32'h0240_0000);
      rdc(`NSMR_OFS_STATUS, 32'h0);
      chk(32'(tx_start_level), 32'h40);
      $display("test reset values done");
      for (int i = 0; i < 11; i++) begin
         ev(ecode[i]);
         rdc(`NSMR_OFS_STATUS, estat[i]);
         wr(`NSMR_OFS_STATUS, 32'h0);
         rdc(`NSMR_OFS_STATUS, estat[i]);
         wr(`NSMR_OFS_STATUS, {18'h0, estat[i][13:0]});
         rdc(`NSMR_OFS_STATUS, 32'h0);
         rdc(`NSMR_OFS_IRQ_STAT, {18'h0, estat[i][13:0]});
      end
      $display("test status flags done");
      for (int i = 0; i < 8; i++) begin
         wr(`NSMR_OFS_OPMODE, {9'h0, i[2], 6'h0, i[1:0], 14'h0});
         repeat (2) @(posedge core_clk);
         chk(32'(tx_start_level), thr[i]);
         tx_fifo_level <= 12'(thr[i]);
         repeat (3) @(posedge core_clk);
         chk(32'(tx_start), 32'h0);
         tx_fifo_level <= 12'(thr[i] + 32'h1);
         repeat (3) @(posedge core_clk);
         chk(32'(tx_start), 32'h1);
      end
      tx_fifo_level <= 12'h000;
      $display("test thresholds done");
      wr(`NSMR_OFS_OPMODE, 32'hFFFF_FFFF);
      rdc(`NSMR_OFS_OPMODE, 32'h6240_C000);
      repeat (2) @(posedge core_clk);
      chk(32'({accept_all_rx, keep_rx_fifo, rx_accept, rx_desc0_match}), 32'hE);
      rx_addr_match <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(32'(rx_desc0_match), 32'h1);
      ev(4'h0);
      chk(32'({rx_suspend, rx_purge}), 32'h2);
      wr(`NSMR_OFS_OPMODE, 32'h0);
      repeat (2) @(posedge core_clk);
      chk(32'({rx_suspend, rx_purge}), 32'h3);
      ev(4'h3);
      chk(32'({rx_suspend, rx_purge}), 32'h0);
      ev(4'h0);
      ev(4'h2);
      chk(32'(rx_suspend), 32'h0);
      ev(4'h9);
      chk(32'({tx_suspend, tx_desc0_underrun}), 32'h2);
      ev(4'hC);
      chk(32'(tx_suspend), 32'h0);
      ev(4'h7);
      chk(32'(tx_suspend), 32'h1);
      ev(4'hB);
      chk(32'(tx_suspend), 32'h0);
      wr(`NSMR_OFS_STATUS, 32'h3FFF);
      rd(`NSMR_OFS_IRQ_STAT);
      $display("test mode and suspend done");
      wr(`NSMR_OFS_IRQ_MASK, 32'h1);
      rdc(`NSMR_OFS_IRQ_MASK, 32'h1);
      ev(4'h8);
      chk(32'(irq), 32'h1);
      rdc(`NSMR_OFS_IRQ_STAT, 32'h1);
      chk(32'(irq), 32'h0);
      ev(4'h1);
      chk(32'(irq), 32'h0);
      rdc(`NSMR_OFS_IRQ_STAT, 32'h40);
      rdc(`NSMR_OFS_STATUS, 32'h0001_0041);
      wr(`NSMR_OFS_STATUS, 32'h41);
      wr(8'h10, 32'hFFFF_FFFF);
      chk(32'(rsp), 32'h2);
      rd(8'h10);
      chk(32'(rsp), 32'h2);
      rdc(`NSMR_OFS_STATUS, 32'h0);
      $display("test interrupt and unmapped done");
      end_sim();
   end
endmodule
